/* File: verilog/sad_access.sv */
/*
   serial master giving i/o-mapped access to the on-board a/d and d/a
   converters: control, rate/status and four shift bytes on the host side,
   a frame engine on the link clock on the other. assumes the host bus is
   synchronous to clk and the converters sample and drive on link edges.
*/
`timescale 1ns/1ns
`include "sad_map.svh"
module sad_access
   import sad_pkg::*;
#(
   parameter int ADC_CHANNELS = 8,
   parameter int DAC_CHANNELS = 4
) (
   // system clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // host i/o bus
   input wire logic [9:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // link clock and its reset
   input wire logic link_clk,
   input wire logic link_rst_b,
   // serial link to the converters
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic [7:0] cs_b
);

   sad_sys_s s_ff;
   sad_sys_s nxt_s;
   sad_link_s l_ff;
   sad_link_s nxt_l;

   logic done_sync;
   logic go_sync;
   logic miso_sync;

   // the frame handshake is a toggle each way
   sad_sync #(.WIDTH(1)) u_done_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(l_ff.done_tgl),
      .q(done_sync)
   );

   sad_sync #(.WIDTH(2)) u_link_sync (
      .clk(link_clk),
      .rst_b(link_rst_b),
      .d({s_ff.go_tgl, miso}),
      .q({go_sync, miso_sync})
   );

   logic wr_cfg;
   logic wr_rate;
   logic wr_byte3;
   logic frame_done;

   always_comb begin
      wr_cfg = io_wr && (io_addr == `SAD_OFS_CONFIG);
      wr_rate = io_wr && (io_addr == `SAD_OFS_STATUS);
      wr_byte3 = io_wr && (io_addr == `SAD_OFS_BYTE3);
      frame_done = done_sync != s_ff.done_seen;
   end

   // host side: registers, start and completion
   always_comb begin
      nxt_s = s_ff;
      nxt_s.done_seen = done_sync;
      // no interrupt exists: completion is seen only through busy
      if (frame_done) begin
         nxt_s.busy = 1'b0;
         nxt_s.dat = l_ff.w;
      end
      // writes while a frame runs are dropped so the link sees steady words
      if (io_wr && !s_ff.busy) begin
         if (wr_cfg) begin
            nxt_s.cfg = io_wdata;
         end else if (wr_rate) begin
            nxt_s.rate = {io_wdata[7:1], 1'b0};
         end else if (io_addr == `SAD_OFS_BYTE0) begin
            nxt_s.dat[7:0] = io_wdata;
         end else if (io_addr == `SAD_OFS_BYTE1) begin
            nxt_s.dat[15:8] = io_wdata;
         end else if (io_addr == `SAD_OFS_BYTE2) begin
            nxt_s.dat[23:16] = io_wdata;
         end else if (wr_byte3) begin
            nxt_s.dat[31:24] = io_wdata;
            nxt_s.busy = 1'b1;
            nxt_s.go_tgl = ~s_ff.go_tgl;
         end
      end
      nxt_s.rdata = 8'h00;
      if (io_rd) begin
         if (io_addr == `SAD_OFS_CONFIG) begin
            nxt_s.rdata = s_ff.cfg;
         end else if (io_addr == `SAD_OFS_STATUS) begin
            nxt_s.rdata = {s_ff.rate[7:1], s_ff.busy};
         end else if (io_addr == `SAD_OFS_BYTE0) begin
            nxt_s.rdata = s_ff.dat[7:0];
         end else if (io_addr == `SAD_OFS_BYTE1) begin
            nxt_s.rdata = s_ff.dat[15:8];
         end else if (io_addr == `SAD_OFS_BYTE2) begin
            nxt_s.rdata = s_ff.dat[23:16];
         end else if (io_addr == `SAD_OFS_BYTE3) begin
            nxt_s.rdata = s_ff.dat[31:24];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_ff.cfg <= `SAD_CONFIG_RST;
         s_ff.rate <= `SAD_RATE_RST;
         s_ff.dat <= `SAD_DATA_RST;
         s_ff.busy <= 1'b0;
         s_ff.go_tgl <= 1'b0;
         s_ff.done_seen <= 1'b0;
         s_ff.rdata <= 8'h00;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign io_rdata = s_ff.rdata;

   // link side. cfg, rate and dat are held still by the host while busy,
   // so apart from cpol, which drives sclk while idle, the engine reads them only after the start toggle has crossed.
   logic [2:0] half;
   logic [5:0] nbits;
   logic [31:0] win_mask;
   logic [31:0] ins_pos;
   logic [2:0] sel;
   logic cpol;
   logic cpha;
   logic man;

   always_comb begin
      half = `SAD_HALF_BASE - {1'b0, s_ff.rate[`SAD_ST_RATE_HI:`SAD_ST_RATE_LO]};
      // 00 -> 8, 01 -> 16, 10 -> 24, 11 -> 32 bits
      nbits = {1'b0, s_ff.cfg[`SAD_CFG_LEN_HI:`SAD_CFG_LEN_LO], 3'h0} + 6'h08;
      win_mask = 32'hFFFF_FFFF << (6'h20 - nbits);
      ins_pos = 32'h0000_0001 << (6'h20 - nbits);
      sel = s_ff.cfg[`SAD_CFG_SEL_HI:`SAD_CFG_SEL_LO];
      cpol = s_ff.cfg[`SAD_CFG_CPOL];
      cpha = s_ff.cfg[`SAD_CFG_CPHA];
      man = s_ff.cfg[`SAD_CFG_MAN];
   end

   always_comb begin
      nxt_l = l_ff;
      nxt_l.go_seen = go_sync;
      case (l_ff.st)
         SAD_LK_IDLE: begin
            nxt_l.sclk = cpol;
            if (go_sync != l_ff.go_seen) begin
               nxt_l.st = SAD_LK_SETUP;
               nxt_l.w = s_ff.dat;
               nxt_l.mosi = s_ff.dat[31];
               nxt_l.hc = 3'h0;
               nxt_l.ph = 1'b0;
               nxt_l.bc = 6'h00;
               nxt_l.cs_b = 8'hFF;
               nxt_l.cs_b[sel] = 1'b0;
            end
         end
         SAD_LK_SETUP: begin
            // select settles one half period before the first edge with cpha set, a whole period with cpha clear
            nxt_l.hc = l_ff.hc + 3'h1;
            if (l_ff.hc + 3'h1 >= half) begin
               nxt_l.hc = 3'h0;
               nxt_l.st = SAD_LK_SHIFT;
               nxt_l.sclk = cpha ^ cpol;
            end
         end
         SAD_LK_SHIFT: begin
            nxt_l.hc = l_ff.hc + 3'h1;
            if (l_ff.hc + 3'h1 >= half) begin
               nxt_l.hc = 3'h0;
               nxt_l.ph = ~l_ff.ph;
               nxt_l.sclk = (~l_ff.ph ^ cpha) ^ cpol;
               if (l_ff.ph) begin
                  // bit ends: capture the returned bit into the frame window,
                  // the bytes below the window keep their written value
                  nxt_l.w = ((l_ff.w << 1) & win_mask & ~ins_pos)
                     | (miso_sync ? ins_pos : 32'h0000_0000)
                     | (l_ff.w & ~win_mask);
                  nxt_l.mosi = l_ff.w[30];
                  nxt_l.bc = l_ff.bc + 6'h01;
                  if (l_ff.bc + 6'h01 == nbits) begin
                     nxt_l.st = SAD_LK_HOLD;
                     nxt_l.sclk = cpol;
                  end else begin
                     nxt_l.sclk = cpha ^ cpol;
                  end
               end
            end
         end
         SAD_LK_HOLD: begin
            nxt_l.hc = l_ff.hc + 3'h1;
            if (l_ff.hc + 3'h1 >= half) begin
               nxt_l.hc = 3'h0;
               nxt_l.st = SAD_LK_IDLE;
               // manual select keeps the device selected between frames
               nxt_l.held = man;
               if (!man) begin
                  nxt_l.cs_b = 8'hFF;
               end
               nxt_l.done_tgl = ~l_ff.done_tgl;
            end
         end
         default: begin
            nxt_l.st = SAD_LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
         l_ff.st <= SAD_LK_IDLE;
         l_ff.hc <= 3'h0;
         l_ff.ph <= 1'b0;
         l_ff.bc <= 6'h00;
         l_ff.w <= 32'h0000_0000;
         l_ff.sclk <= 1'b0;
         l_ff.mosi <= 1'b0;
         l_ff.cs_b <= 8'hFF;
         l_ff.go_seen <= 1'b0;
         l_ff.done_tgl <= 1'b0;
         l_ff.held <= 1'b0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   assign sclk = l_ff.sclk;
   assign mosi = l_ff.mosi;
   assign cs_b = l_ff.cs_b;

   // checks on the host side
   sequence s_start;
      io_wr && (io_addr == `SAD_OFS_BYTE3) && !s_ff.busy;
   endsequence

   sequence s_busy_set;
      s_ff.busy [*2];
   endsequence

   a_start_busy: assert property (
      @(posedge clk) disable iff (!rst_b)
      s_start |=> s_busy_set)
      else $error("byte 3 write did not start a frame");

   a_busy_fall: assert property (
      @(posedge clk) disable iff (!rst_b)
      $fell(s_ff.busy) |-> $past(frame_done))
      else $error("busy fell without frame completion");

   a_status_read: assert property (
      @(posedge clk) disable iff (!rst_b)
      io_rd && (io_addr == `SAD_OFS_STATUS) |=> io_rdata[0] == $past(s_ff.busy))
      else $error("status bit 0 does not show busy");

   a_result_load: assert property (
      @(posedge clk) disable iff (!rst_b)
      frame_done |=> s_ff.dat == $past(l_ff.w) && !s_ff.busy)
      else $error("frame result not loaded into shift bytes");

   a_busy_locks: assert property (
      @(posedge clk) disable iff (!rst_b)
      s_ff.busy && !frame_done |=> $stable(s_ff.cfg) && $stable(s_ff.go_tgl))
      else $error("settings changed while frame running");

   a_busy_dat_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      s_ff.busy && !frame_done |=> $stable(s_ff.dat))
      else $error("shift bytes changed while frame running");

   a_go_busy: assert property (
      @(posedge clk) disable iff (!rst_b)
      $changed(s_ff.go_tgl) |-> s_ff.busy)
      else $error("frame started without busy set");

   a_rdata_idle: assert property (
      @(posedge clk) disable iff (!rst_b)
      !io_rd |=> io_rdata == 8'h00)
      else $error("read data not cleared without a read");

   // checks on the link side
   a_idle_clock: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      l_ff.st == SAD_LK_IDLE |-> l_ff.sclk == cpol)
      else $error("serial clock not idle outside frame");

   a_select_frame: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      l_ff.st == SAD_LK_SHIFT |-> l_ff.cs_b[sel] == 1'b0 && $countones(~l_ff.cs_b) == 1)
      else $error("select not held through the frame");

   a_edge_selected: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      $changed(l_ff.sclk) |-> l_ff.cs_b != 8'hFF)
      else $error("clock edge with no device selected");

   a_dac_select: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      l_ff.st == SAD_LK_SHIFT && sel == `SAD_SEL_DAC |-> !l_ff.cs_b[7])
      else $error("d/a select code 7 not driving select 7");

   a_bit_count: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      l_ff.st == SAD_LK_SHIFT ##1 l_ff.st == SAD_LK_HOLD |-> l_ff.bc == nbits)
      else $error("frame length differs from configured length");

   a_done_after: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      $changed(l_ff.done_tgl) |-> $past(l_ff.st) == SAD_LK_HOLD)
      else $error("completion signalled before hold ended");

   // the select must lead the first clock edge by a whole setup phase
   sequence s_enter_setup;
      l_ff.st == SAD_LK_IDLE ##1 l_ff.st == SAD_LK_SETUP;
   endsequence

   a_select_lead: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      s_enter_setup |-> !l_ff.cs_b[sel] && l_ff.sclk == cpol)
      else $error("select not asserted ahead of first clock edge");

   a_select_release: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      l_ff.st == SAD_LK_IDLE && !l_ff.held |-> l_ff.cs_b == 8'hFF)
      else $error("select left active after an automatic frame");

   a_mosi_boundary: assert property (
      @(posedge link_clk) disable iff (!link_rst_b)
      $changed(l_ff.mosi) |-> $past(l_ff.st) == SAD_LK_IDLE
         || ($past(l_ff.st) == SAD_LK_SHIFT && $past(l_ff.ph)))
      else $error("serial data changed inside a bit");

endmodule

/* File: verilog/sad_map.svh */
/*
   register offsets, field positions, reset values and timing counts of the
   converter access block. assumes an 8-bit i/o bus decoding 10-bit addresses.
*/
// Summary of operation
// - a/d gives 12-bit samples, 8 channels
// - a/d completion never raises an interrupt
// - byte 2 content ignored by a/d converter
// - a byte 3 write starts a frame unless busy
// - status bit 0 high while frame runs
// - 16-bit a/d result lands in bytes 2,3
// - a/d result lags channel choice one conversion
// - first a/d frame after reset returns channel 0
// - 32-bit frame performs two back-to-back conversions
// - 32-bit result readable in bytes 0 and 1
// - results are straight unsigned binary, 4096 codes
// - d/a reached through select code 7
// - config bits 5-4 give frame length
// - block is sole master, drives serial clock
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH

`define SAD_OFS_CONFIG 10'h1E8
`define SAD_OFS_STATUS 10'h1E9
`define SAD_OFS_BYTE0 10'h1EA
`define SAD_OFS_BYTE1 10'h1EB
`define SAD_OFS_BYTE2 10'h1EC
`define SAD_OFS_BYTE3 10'h1ED

`define SAD_CONFIG_RST 8'h00
`define SAD_RATE_RST 8'h00
`define SAD_DATA_RST 32'h0000_0000

`define SAD_CFG_CPOL 7
`define SAD_CFG_CPHA 6
`define SAD_CFG_LEN_HI 5
`define SAD_CFG_LEN_LO 4
`define SAD_CFG_MAN 3
`define SAD_CFG_SEL_HI 2
`define SAD_CFG_SEL_LO 0
`define SAD_ST_BUSY 0
`define SAD_ST_RATE_HI 5
`define SAD_ST_RATE_LO 4

`define SAD_SEL_ADC 3'h5
`define SAD_SEL_DAC 3'h7

// half serial-clock period in link cycles is base minus the rate field
`define SAD_HALF_BASE 3'h5

`endif

/* File: verilog/sad_pkg.sv */
/*
   types of the converter access block: link states and state records.
   assumes sad_map.svh supplies the numeric constants.
*/
package sad_pkg;

   typedef enum logic [1:0] {
      SAD_LK_IDLE,
      SAD_LK_SETUP,
      SAD_LK_SHIFT,
      SAD_LK_HOLD
   } sad_link_e;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] rate;
      logic [31:0] dat;
      logic busy;
      logic go_tgl;
      logic done_seen;
      logic [7:0] rdata;
   } sad_sys_s;

   typedef struct packed {
      sad_link_e st;
      logic [2:0] hc;
      logic ph;
      logic [5:0] bc;
      logic [31:0] w;
      logic sclk;
      logic mosi;
      logic [7:0] cs_b;
      logic go_seen;
      logic done_tgl;
      logic held;
   } sad_link_s;

endpackage

/* File: verilog/sad_sync.sv */
/*
   two-stage synchroniser for levels and toggles entering a clock domain.
   assumes the input is a level that may change at any time.
*/
`timescale 1ns/1ns
module sad_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset of the receiving domain
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous level in, synchronised level out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sad_sync_s;

   sad_sync_s r_ff;
   sad_sync_s nxt_r;

   // the first stage feeds only the second stage
   always_comb begin
      nxt_r.s1 = d;
      nxt_r.s2 = r_ff.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign q = r_ff.s2;

endmodule

/* File: dv/sad_conv_model.sv */
/*
   behavioural a/d and d/a converters on the serial link of the access block.
   assumes mode 0 framing: data sampled on sclk rise, changed on sclk fall.
*/
`timescale 1ns/1ns
module sad_conv_model (
   // link driven by the block
   input wire logic link_rst_b,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic [7:0] cs_b,
   // converter answer and what was seen
   output logic miso,
   output logic [15:0] dac_word,
   output logic [6:0] last_bits
);
   logic [15:0] rx;
   logic [15:0] tx;
   logic [2:0] prev_ch;
   logic [3:0] cnt;

   // first frame after reset answers with channel 0; a declared initial
   // value of the reset gives no edge at time zero, so seed it here too
   initial prev_ch = 3'h0;
   always @(negedge link_rst_b) prev_ch = 3'h0;
   always @(negedge cs_b[5] or negedge cs_b[7]) begin
      cnt = 4'h0;
      last_bits = 7'h00;
      tx = {1'b0, 3'h0, 1'b1, prev_ch, 8'h3C};
   end
   // only the selected converter listens
   always @(posedge sclk) begin
      if (cs_b[5] == 1'b0 || cs_b[7] == 1'b0) begin
         rx = {rx[14:0], mosi};
         cnt = cnt + 4'h1;
         last_bits = last_bits + 7'h01;
         if (cnt == 4'h0 && cs_b[5] == 1'b0) prev_ch = rx[13:11];
         if (cnt == 4'h0 && cs_b[7] == 1'b0) dac_word = rx;
      end
   end
   always @(negedge sclk) begin
      if (cs_b[5] == 1'b0) begin
         if (cnt == 4'h0) tx = {4'h0, 1'b1, prev_ch, 8'h3C};
         else tx = tx << 1;
      end
   end
   // released line shows the inverse of the last bit, not a stale copy
   assign miso = cs_b[5] ? ~tx[15] : tx[15];
endmodule

/* File: dv/tb.sv */
/*
   self-checking bench of the converter access block with converter model.
   assumes the host bus is driven on falling clk edges and read one cycle on.
*/
`timescale 1ns/1ns
`include "sad_map.svh"
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic link_clk = 1'b0;
   logic link_rst_b = 1'b0;
   logic [9:0] io_addr = 10'h000;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic sclk, mosi, miso;
   logic [7:0] cs_b;
   logic [15:0] dac_word;
   logic [6:0] last_bits;
   logic armed = 1'b0;
   int n_mismatch = 0;
   int comparisons = 0;
   int stray = 0;

   always #5 clk = ~clk;
   // 62 plus 63 keeps the 125 ns link period exact on a 1 ns grid
   always begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
   end

   sad_access u_dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .link_clk(link_clk),
      .link_rst_b(link_rst_b), .sclk(sclk), .mosi(mosi), .miso(miso), .cs_b(cs_b));
   sad_conv_model u_conv (.link_rst_b(link_rst_b), .sclk(sclk), .mosi(mosi),
      .cs_b(cs_b), .miso(miso), .dac_word(dac_word), .last_bits(last_bits));

   always @(sclk) if (armed && cs_b === 8'hFF) stray++;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic io_write(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask

   task automatic io_read(input logic [9:0] a, output logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      d = io_rdata;
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      logic [7:0] d;
      io_read(a, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask

   task automatic wait_idle();
      logic [7:0] s;
      int i;
      s = 8'h01;
      i = 0;
      while (s[0] !== 1'b0 && i < 4000) begin
         io_read(`SAD_OFS_STATUS, s);
         i++;
      end
      chk({15'h0000, s[0]}, 16'h0000);
   endtask

   task automatic t_reset();
      for (int a = 10'h1E8; a <= 10'h1EE; a++) rd_chk(a[9:0], 8'h00);
   endtask

   task automatic t_adc16();
      io_write(`SAD_OFS_CONFIG, 8'h15);
      io_write(`SAD_OFS_STATUS, 8'h30);
      io_write(`SAD_OFS_BYTE2, 8'hA7);
      io_write(`SAD_OFS_BYTE3, 8'h18);
      rd_chk(`SAD_OFS_STATUS, 8'h31);
      io_write(`SAD_OFS_CONFIG, 8'h00);
      repeat (100) @(negedge clk);
      chk({8'h00, cs_b}, 16'h00DF);
      wait_idle();
      chk({7'h00, sclk, cs_b}, 16'h00FF);
      rd_chk(`SAD_OFS_CONFIG, 8'h15);
      rd_chk(`SAD_OFS_STATUS, 8'h30);
      rd_chk(`SAD_OFS_BYTE2, 8'h3C);
      rd_chk(`SAD_OFS_BYTE3, 8'h08);
      chk({9'h000, last_bits}, 16'h0010);
      io_write(`SAD_OFS_BYTE3, 8'h28);
      wait_idle();
      rd_chk(`SAD_OFS_BYTE3, 8'h0B);
   endtask

   task automatic t_adc32();
      io_write(`SAD_OFS_CONFIG, 8'h35);
      io_write(`SAD_OFS_BYTE1, 8'h00);
      io_write(`SAD_OFS_BYTE3, 8'h30);
      wait_idle();
      rd_chk(`SAD_OFS_BYTE0, 8'h3C);
      rd_chk(`SAD_OFS_BYTE1, 8'h0E);
      chk({9'h000, last_bits}, 16'h0020);
   endtask

   task automatic t_len();
      for (int n = 0; n < 4; n++) begin
         io_write(`SAD_OFS_CONFIG, {2'b00, n[1:0], 4'h5});
         io_write(`SAD_OFS_BYTE3, 8'h00);
         wait_idle();
         chk({9'h000, last_bits}, 16'(8 * (n + 1)));
      end
   endtask

   // manual select keeps the converter selected until an automatic frame ends
   task automatic t_manual();
      io_write(`SAD_OFS_CONFIG, 8'h1D);
      io_write(`SAD_OFS_BYTE3, 8'h00);
      wait_idle();
      chk({8'h00, cs_b}, 16'h00DF);
      io_write(`SAD_OFS_CONFIG, 8'h15);
      io_write(`SAD_OFS_BYTE3, 8'h00);
      wait_idle();
      chk({8'h00, cs_b}, 16'h00FF);
   endtask

   task automatic t_dac();
      io_write(`SAD_OFS_CONFIG, 8'h17);
      io_write(`SAD_OFS_BYTE2, 8'h23);
      io_write(`SAD_OFS_BYTE3, 8'h91);
      wait_idle();
      repeat (500) @(negedge clk);
      chk(dac_word, 16'h9123);
      chk({9'h000, last_bits}, 16'h0010);
      chk({8'h00, cs_b}, 16'h00FF);
   endtask

   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #500000;
      n_mismatch++;
      summarize();
   end

   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      // link reset needs three link edges, far more than ten clk cycles
      repeat (30) @(negedge clk);
      link_rst_b = 1'b1;
      repeat (10) @(negedge clk);
      armed = 1'b1;
      t_reset();
      t_adc16();
      t_adc32();
      t_len();
      t_manual();
      t_dac();
      chk(16'(stray), 16'h0000);
      summarize();
   end
endmodule
